/* src/sector_protect_pkg.sv */
// Constants, types and carriers shared by the sector protection control block
//
// Behaviour
// - While protection is in force, refuse program or erase on a guarded sector.
// - Guard pin low puts protection in force within the guard assert delay.
// - Guard pin released without software enable drops protection after release delay.
// - Software enable before or during guard low keeps protection after release.
// - Software disable is ignored while the guard pin is low.
// - Guard high, no enable: disabled; enable turns it on, disable off.
// - Guard input is filtered so glitches neither assert nor release it.
// - Map holds one byte per sector, sectors zero to thirty-one.
// - All ones marks a sector guarded, all zeros unguarded; erased means guarded.
// - Sector zero: bits 7:6 pages 0-7, bits 5:4 pages 8-255, 3:0 ignored.
// - Map leaves the factory with every byte cleared.
// - Bytes 3D 2A 7F CF then chip select rise run a timed map erase, busy.
// - Map erase is accepted whether protection is in force or not.
// - After map erase all sectors are guarded until reprogrammed.
// - Bytes 3D 2A 7F FC then thirty-two map bytes, sector zero first.
// - Chip select rise after data starts a timed map program, busy until done.
// - Map write pointer wraps; the thirty-third byte lands in location zero.
// - Map program is accepted whether protection is in force or not.
// - Map program uses the data buffer as working storage, overwriting it; here the program cycle only reads the buffer and leaves it as loaded.
// - Bytes 3D 2A 7F A9 enable protection at chip select rise.
// - Bytes 3D 2A 7F 9A disable protection at chip select rise.
// - Software protection state starts cleared at power-up.
package sector_protect_pkg;

  // Command bytes
  localparam logic [7:0] OPC_PREFIX_0 = 8'h3d;
  localparam logic [7:0] OPC_PREFIX_1 = 8'h2a;
  localparam logic [7:0] OPC_PREFIX_2 = 8'h7f;
  localparam logic [7:0] OPC_ENABLE = 8'ha9;
  localparam logic [7:0] OPC_DISABLE = 8'h9a;
  localparam logic [7:0] OPC_ERASE = 8'hcf;
  localparam logic [7:0] OPC_PROGRAM = 8'hfc;

  // Map layout
  localparam int MAP_BYTES = 32;
  localparam logic [7:0] MAP_ERASED = 8'hff;
  localparam logic [7:0] MAP_FACTORY = 8'h00;
  localparam int SUB0_LOW_HI = 7;
  localparam int SUB0_LOW_LO = 6;
  localparam int SUB0_HIGH_HI = 5;
  localparam int SUB0_HIGH_LO = 4;
  localparam logic [7:0] SUB0_LOW_LAST_PAGE = 8'h07;
  localparam logic [4:0] SECTOR_ZERO = 5'h00;

  // Frame decoding
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] HDR_LAST = 3'h3;
  localparam logic [2:0] HDR_DONE = 3'h4;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int GUARD_FILTER_NS = 100;
  localparam int GUARD_FILTER_CYCLES = (GUARD_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] GUARD_FILTER_LAST = 4'(GUARD_FILTER_CYCLES - 1);

  typedef enum logic [4:0] {
    CMD_NONE = 5'b0_0001,
    CMD_ENABLE = 5'b0_0010,
    CMD_DISABLE = 5'b0_0100,
    CMD_ERASE = 5'b0_1000,
    CMD_PROGRAM = 5'b1_0000
  } cmd_type;

  typedef logic [MAP_BYTES-1:0][7:0] map_type;

  typedef struct packed {
    logic valid;
    logic [4:0] sector;
    logic [7:0] page;
  } op_req_type;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [2:0] hdr_cnt;
    logic [4:0] data_idx;
    logic prefix_ok;
    logic started;
  } link_frame_type;

  typedef struct packed {
    logic [6:0] shift;
    cmd_type cmd;
    map_type buffer;
  } link_data_type;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic guard_s1;
    logic guard_s2;
    logic guard_low;
    logic [3:0] filt_cnt;
    logic sw_en;
    logic prot;
    logic busy;
    logic [15:0] busy_cnt;
    map_type map;
    logic op_grant;
    logic op_refuse;
  } core_type;

endpackage : sector_protect_pkg

/* src/sector_protect_control.sv */
// Sector protection control: guard pin filter, protection state, map commands
`timescale 1ns/10ps
`default_nettype none

module sector_protect_control #(
  parameter int map_erase_time_us = 50,
  parameter int map_program_time_us = 50
) (
  // System
  input wire logic ref_clk,
  input wire logic arst_n,
  // Command link, clocked by the host
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic byte_mode,
  input wire logic [7:0] byte_port_lines,
  // Write guard pin
  input wire logic guard_n,
  // Program and erase check from the array controller
  input wire sector_protect_pkg::op_req_type op_req,
  output logic op_grant,
  output logic op_refuse,
  // Status
  output logic busy,
  output logic prot_in_force,
  output logic sw_prot_enabled
);

  localparam int ERASE_CYCLES = map_erase_time_us * sector_protect_pkg::NS_PER_US /
                                sector_protect_pkg::CLK_PERIOD_NS;
  localparam int PROGRAM_CYCLES = map_program_time_us * sector_protect_pkg::NS_PER_US /
                                  sector_protect_pkg::CLK_PERIOD_NS;
  localparam logic [15:0] ERASE_LAST = 16'(ERASE_CYCLES - 1);
  localparam logic [15:0] PROGRAM_LAST = 16'(PROGRAM_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: frame counters cleared by chip select, command and buffer kept

  sector_protect_pkg::link_frame_type frame;
  sector_protect_pkg::link_frame_type next_frame;
  sector_protect_pkg::link_data_type ldata;
  sector_protect_pkg::link_data_type next_ldata;
  logic byte_done;
  logic [7:0] byte_val;

  always_comb begin
    next_frame = frame;
    next_ldata = ldata;
    byte_done = byte_mode | (frame.bit_cnt == sector_protect_pkg::BIT_LAST);
    byte_val = byte_mode ? byte_port_lines : {ldata.shift, serial_in};
    next_frame.started = 1'b1;
    // A new frame forgets the previous command before anything else
    if (!frame.started) begin
      next_ldata.cmd = sector_protect_pkg::CMD_NONE;
    end
    if (byte_mode) begin
      next_frame.bit_cnt = 3'h0;
    end else begin
      next_frame.bit_cnt = 3'(frame.bit_cnt + 3'h1);
      next_ldata.shift = {ldata.shift[5:0], serial_in};
    end
    if (byte_done) begin
      if (frame.hdr_cnt < sector_protect_pkg::HDR_DONE) begin
        next_frame.hdr_cnt = 3'(frame.hdr_cnt + 3'h1);
        case (frame.hdr_cnt)
          3'h0: begin
            next_frame.prefix_ok = frame.prefix_ok & (byte_val == sector_protect_pkg::OPC_PREFIX_0);
          end
          3'h1: begin
            next_frame.prefix_ok = frame.prefix_ok & (byte_val == sector_protect_pkg::OPC_PREFIX_1);
          end
          3'h2: begin
            next_frame.prefix_ok = frame.prefix_ok & (byte_val == sector_protect_pkg::OPC_PREFIX_2);
          end
          sector_protect_pkg::HDR_LAST: begin
            if (frame.prefix_ok) begin
              case (byte_val)
                sector_protect_pkg::OPC_ENABLE: begin
                  next_ldata.cmd = sector_protect_pkg::CMD_ENABLE;
                end
                sector_protect_pkg::OPC_DISABLE: begin
                  next_ldata.cmd = sector_protect_pkg::CMD_DISABLE;
                end
                sector_protect_pkg::OPC_ERASE: begin
                  next_ldata.cmd = sector_protect_pkg::CMD_ERASE;
                end
                sector_protect_pkg::OPC_PROGRAM: begin
                  next_ldata.cmd = sector_protect_pkg::CMD_PROGRAM;
                end
                default: begin
                  next_ldata.cmd = sector_protect_pkg::CMD_NONE;
                end
              endcase
            end
          end
          default: begin
            next_frame.prefix_ok = 1'b0;
          end
        endcase
      end else if (ldata.cmd == sector_protect_pkg::CMD_PROGRAM) begin
        // Data bytes land in the shared data buffer, sector zero first
        next_ldata.buffer[frame.data_idx] = byte_val;
        next_frame.data_idx = 5'(frame.data_idx + 5'h01);
      end
    end
  end

  // Chip select high holds the frame counters at rest; the link clock may stop
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      frame <= '{bit_cnt: 3'h0, hdr_cnt: 3'h0, data_idx: 5'h00, prefix_ok: 1'b1, started: 1'b0};
    end else begin
      frame <= next_frame;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      ldata <= '{shift: 7'h00, cmd: sector_protect_pkg::CMD_NONE, buffer: '0};
    end else begin
      ldata <= next_ldata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: guard filter, protection state, map cycles, operation check

  sector_protect_pkg::core_type core;
  sector_protect_pkg::core_type next_core;
  logic cs_rise;
  logic [7:0] map_byte;
  logic guarded;

  always_comb begin
    next_core = core;
    next_core.cs_s1 = cs_n;
    next_core.cs_s2 = core.cs_s1;
    next_core.cs_prev = core.cs_s2;
    next_core.guard_s1 = guard_n;
    next_core.guard_s2 = core.guard_s1;
    cs_rise = core.cs_s2 & ~core.cs_prev;

    // Guard level must differ from the filtered one for a full window to flip it
    if (core.guard_s2 == core.guard_low) begin
      if (core.filt_cnt == sector_protect_pkg::GUARD_FILTER_LAST) begin
        next_core.guard_low = ~core.guard_low;
        next_core.filt_cnt = 4'h0;
      end else begin
        next_core.filt_cnt = 4'(core.filt_cnt + 4'h1);
      end
    end else begin
      next_core.filt_cnt = 4'h0;
    end

    // Busy countdown of a self-timed map cycle
    if (core.busy) begin
      if (core.busy_cnt == 16'h0000) begin
        next_core.busy = 1'b0;
      end else begin
        next_core.busy_cnt = 16'(core.busy_cnt - 16'h0001);
      end
    end

    // Command is stable here: the link is idle once chip select has risen
    if (cs_rise && !core.busy) begin
      case (ldata.cmd)
        sector_protect_pkg::CMD_ENABLE: begin
          next_core.sw_en = 1'b1;
        end
        sector_protect_pkg::CMD_DISABLE: begin
          if (!core.guard_low) begin
            next_core.sw_en = 1'b0;
          end
        end
        sector_protect_pkg::CMD_ERASE: begin
          // Taken regardless of protection; every sector reads guarded at once
          next_core.map = {sector_protect_pkg::MAP_BYTES{sector_protect_pkg::MAP_ERASED}};
          next_core.busy = 1'b1;
          next_core.busy_cnt = ERASE_LAST;
        end
        sector_protect_pkg::CMD_PROGRAM: begin
          // Programming only clears bits, so an unerased map cannot be raised
          next_core.map = core.map & ldata.buffer;
          next_core.busy = 1'b1;
          next_core.busy_cnt = PROGRAM_LAST;
        end
        default: begin
          next_core.busy = core.busy;
        end
      endcase
    end

    // Hardware guard or software enable each put protection in force
    next_core.prot = next_core.sw_en | next_core.guard_low;

    // Any bit set in the field that covers the page is treated as guarded, the safe side of odd values
    map_byte = core.map[op_req.sector];
    if (op_req.sector == sector_protect_pkg::SECTOR_ZERO) begin
      if (op_req.page <= sector_protect_pkg::SUB0_LOW_LAST_PAGE) begin
        guarded = |map_byte[sector_protect_pkg::SUB0_LOW_HI:sector_protect_pkg::SUB0_LOW_LO];
      end else begin
        guarded = |map_byte[sector_protect_pkg::SUB0_HIGH_HI:sector_protect_pkg::SUB0_HIGH_LO];
      end
    end else begin
      guarded = |map_byte;
    end
    next_core.op_grant = op_req.valid & ~(core.prot & guarded);
    next_core.op_refuse = op_req.valid & core.prot & guarded;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, guard_s1: 1'b1, guard_s2: 1'b1,
                guard_low: 1'b0, filt_cnt: 4'h0, sw_en: 1'b0, prot: 1'b0, busy: 1'b0,
                busy_cnt: 16'h0000,
                map: {sector_protect_pkg::MAP_BYTES{sector_protect_pkg::MAP_FACTORY}},
                op_grant: 1'b0, op_refuse: 1'b0};
    end else begin
      core <= next_core;
    end
  end

  assign op_grant = core.op_grant;
  assign op_refuse = core.op_refuse;
  assign busy = core.busy;
  assign prot_in_force = core.prot;
  assign sw_prot_enabled = core.sw_en;

endmodule : sector_protect_control

`default_nettype wire

/* dv/sector_protect_control_monitor.sv */
// Assertion checker on the sector protection control ports
`timescale 1ns/10ps
`default_nettype none
module sector_protect_control_monitor #(
  parameter int map_erase_time_us = 50,
  parameter int map_program_time_us = 50
) (
  // System
  input wire logic ref_clk,
  input wire logic arst_n,
  // Guard pin and operation check
  input wire logic guard_n,
  input wire sector_protect_pkg::op_req_type op_req,
  input wire logic op_grant,
  input wire logic op_refuse,
  // Status
  input wire logic busy,
  input wire logic prot_in_force,
  input wire logic sw_prot_enabled
);
  localparam int e_us = map_erase_time_us;
  localparam int p_us = map_program_time_us;
  localparam int min_busy = ((e_us < p_us) ? e_us : p_us) * 100;
  logic [4:0] lo_cnt;
  logic [4:0] hi_cnt;
  logic [15:0] busy_len;
  // Saturating run lengths of the raw pin level, so glitches reset them
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt <= 5'h00;
      hi_cnt <= 5'h00;
      busy_len <= 16'h0000;
    end else begin
      lo_cnt <= guard_n ? 5'h00 : lo_cnt + {4'h0, lo_cnt != 5'h1f};
      hi_cnt <= !guard_n ? 5'h00 : hi_cnt + {4'h0, hi_cnt != 5'h1f};
      busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////
  a_answer_once: assert property (op_req.valid |=> op_grant ^ op_refuse)
    else $error("check request not answered once");
  a_no_stray: assert property (!op_req.valid |=> !op_grant && !op_refuse)
    else $error("answer without request");
  a_open_grant: assert property (op_req.valid && !prot_in_force |=> op_grant)
    else $error("refused while unprotected");
  a_sw_holds: assert property (sw_prot_enabled |-> prot_in_force)
    else $error("software enable without protection");
  a_guard_assert: assert property (lo_cnt >= 5'h10 |-> prot_in_force)
    else $error("guard low without protection");
  a_guard_release: assert property (hi_cnt >= 5'h10 && !sw_prot_enabled |-> !prot_in_force)
    else $error("protection kept after guard release");
  a_rise_filter: assert property ($rose(prot_in_force) && !sw_prot_enabled |-> lo_cnt >= 5'h0a)
    else $error("guard glitch asserted protection");
  a_fall_filter: assert property ($fell(prot_in_force) |-> hi_cnt >= 5'h0a)
    else $error("guard glitch released protection");
  a_disable_guard: assert property ($fell(sw_prot_enabled) |-> hi_cnt >= 5'h0a)
    else $error("disable taken while guard low");
  a_busy_len: assert property ($fell(busy) |-> busy_len >= min_busy)
    else $error("busy too short");
endmodule : sector_protect_control_monitor
bind sector_protect_control sector_protect_control_monitor #(
  .map_erase_time_us(map_erase_time_us), .map_program_time_us(map_program_time_us)
) mon (.ref_clk(ref_clk), .arst_n(arst_n), .guard_n(guard_n), .op_req(op_req),
  .op_grant(op_grant), .op_refuse(op_refuse), .busy(busy),
  .prot_in_force(prot_in_force), .sw_prot_enabled(sw_prot_enabled));
`default_nettype wire

/* dv/sector_protect_host.sv */
// Host model driving command frames over the link
`timescale 1ns/10ps
`default_nettype none
module sector_protect_host (
  // Link to the device
  output var logic link_clk,
  output var logic cs_n,
  output var logic serial_in,
  output var logic byte_mode,
  output var logic [7:0] byte_port_lines
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b1;
    byte_mode = 1'b0;
    byte_port_lines = 8'h00;
  end
  // The link clock only runs inside frames
  task automatic tick();
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
  endtask : tick
  // One frame, MSB first when serial; done at chip select rise
  task automatic send(input logic [7:0] q[$], input logic bm);
    byte_mode = bm;
    #33 cs_n = 1'b0;
    foreach (q[i]) begin
      if (bm) begin
        byte_port_lines = q[i];
        tick();
      end else begin
        for (int b = 7; b >= 0; b--) begin
          serial_in = q[i][b];
          tick();
        end
      end
    end
    #40 cs_n = 1'b1;
    // Released lines flip so a stale level is never mistaken for data
    serial_in = ~serial_in;
    byte_port_lines = ~byte_port_lines;
    #500;
  endtask : send
endmodule : sector_protect_host
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the sector protection control
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic guard_n = 1'b1;
  sector_protect_pkg::op_req_type op_req = '0;
  wire logic link_clk, cs_n, serial_in, byte_mode;
  wire logic [7:0] byte_port_lines;
  logic op_grant, op_refuse, busy, prot_in_force, sw_prot_enabled;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] data[$];
  always #5 ref_clk = ~ref_clk;
  sector_protect_host host (.link_clk(link_clk), .cs_n(cs_n), .serial_in(serial_in),
    .byte_mode(byte_mode), .byte_port_lines(byte_port_lines));
  sector_protect_control #(.map_erase_time_us(1), .map_program_time_us(1)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk), .cs_n(cs_n),
    .serial_in(serial_in), .byte_mode(byte_mode), .byte_port_lines(byte_port_lines),
    .guard_n(guard_n), .op_req(op_req), .op_grant(op_grant), .op_refuse(op_refuse),
    .busy(busy), .prot_in_force(prot_in_force), .sw_prot_enabled(sw_prot_enabled));
  ////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic got, input logic exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  task automatic set_guard(input logic v);
    @(posedge ref_clk);
    guard_n <= v;
  endtask : set_guard
  task automatic op(input logic [4:0] s, input logic [7:0] p, input logic rf);
    @(posedge ref_clk);
    op_req <= '{valid: 1'b1, sector: s, page: p};
    @(posedge ref_clk);
    op_req.valid <= 1'b0;
    #1;
    chk(op_refuse, rf, "refuse");
    chk(op_grant, !rf, "grant");
  endtask : op
  task automatic cmd(input logic [7:0] c, input logic bm);
    logic [7:0] q[$];
    q = {8'h3d, 8'h2a, 8'h7f, c, data};
    host.send(q, bm);
  endtask : cmd
  task automatic idle();
    for (int i = 0; i < 300 && busy !== 1'b0; i++) cycles(1);
    chk(busy, 1'b0, "busy stuck");
  endtask : idle
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    cycles(2);
    chk(sw_prot_enabled, 1'b0, "sw at reset");
    chk(prot_in_force, 1'b0, "prot at reset");
    op(5'h03, 8'h00, 1'b0);
    // Unknown fourth byte decodes to nothing
    cmd(8'h30, 1'b0);
    chk(sw_prot_enabled, 1'b0, "unknown opcode");
    cmd(8'ha9, 1'b0);
    chk(sw_prot_enabled, 1'b1, "sw enable");
    chk(prot_in_force, 1'b1, "prot enable");
    op(5'h03, 8'h00, 1'b0);
    cmd(8'hcf, 1'b1);
    chk(busy, 1'b1, "erase busy");
    // A disable landing inside the busy period is dropped
    cmd(8'h9a, 1'b1);
    idle();
    chk(sw_prot_enabled, 1'b1, "disable while busy");
    op(5'h05, 8'h00, 1'b1);
    // Whole map of 00/FF after an erase, plus one wrapped byte
    for (int k = 0; k < 32; k++) data.push_back(k[0] ? 8'hff : 8'h00);
    data.push_back(8'h3c);
    cmd(8'hfc, 1'b1);
    chk(busy, 1'b1, "program busy");
    idle();
    data.delete();
    op(5'h00, 8'h03, 1'b0);
    op(5'h00, 8'hc8, 1'b1);
    op(5'h01, 8'h00, 1'b1);
    op(5'h02, 8'h00, 1'b0);
    op(5'h1f, 8'h00, 1'b1);
    cmd(8'h9a, 1'b0);
    chk(prot_in_force, 1'b0, "disable");
    op(5'h01, 8'h00, 1'b0);
    set_guard(1'b0);
    cycles(5);
    set_guard(1'b1);
    cycles(20);
    chk(prot_in_force, 1'b0, "glitch");
    set_guard(1'b0);
    cycles(20);
    chk(prot_in_force, 1'b1, "guard low");
    op(5'h01, 8'h00, 1'b1);
    cmd(8'ha9, 1'b0);
    cmd(8'h9a, 1'b0);
    chk(sw_prot_enabled, 1'b1, "disable under guard");
    set_guard(1'b1);
    cycles(20);
    chk(prot_in_force, 1'b1, "kept after release");
    cmd(8'h9a, 1'b1);
    chk(prot_in_force, 1'b0, "disable after release");
    set_guard(1'b0);
    cycles(20);
    set_guard(1'b1);
    cycles(20);
    chk(prot_in_force, 1'b0, "release");
    final_report();
  end
endmodule : tb
`default_nettype wire
